/* File: logic/uea_pkg.sv */
// Shared constants for the endpoint arming and NAK interrupt block.
// Assumes one 10 MHz system clock and a plain firmware register port.
package uea_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [15:0] ADDR_IN_NAK_EN = 16'hE658;
  localparam logic [15:0] ADDR_IN_NAK_RQ = 16'hE659;
  localparam logic [15:0] ADDR_PING_NAK_EN = 16'hE65A;
  localparam logic [15:0] ADDR_PING_NAK_RQ = 16'hE65B;
  localparam logic [15:0] ADDR_USB_EV_EN = 16'hE65C;
  localparam logic [15:0] ADDR_USB_EV_RQ = 16'hE65D;
  localparam logic [15:0] ADDR_EP_EN = 16'hE65E;
  localparam logic [15:0] ADDR_EP_RQ = 16'hE65F;
  localparam logic [15:0] ADDR_ERR_EN = 16'hE662;
  localparam logic [15:0] ADDR_ERR_RQ = 16'hE663;
  localparam logic [15:0] ADDR_ERR_CNT = 16'hE664;
  localparam logic [15:0] ADDR_ERR_CLR = 16'hE665;
  localparam logic [15:0] ADDR_TOGGLE = 16'hE683;
  // Byte counts for endpoints 2, 4, 6, 8; high at base, low at base+1
  localparam logic [15:0] ADDR_EP2_CNT_HIGH = 16'hE690;
  localparam logic [15:0] ADDR_EP4_CNT_HIGH = 16'hE694;
  localparam logic [15:0] ADDR_EP6_CNT_HIGH = 16'hE698;
  localparam logic [15:0] ADDR_EP8_CNT_HIGH = 16'hE69C;
  // Own choice: per-endpoint config (bit 4 auto commit, bit 0 direction in)
  localparam logic [15:0] ADDR_FIFO_CFG_BASE = 16'hE618;
  // Own choice: endpoint types, small endpoint arm, bus speed
  localparam logic [15:0] ADDR_EP_TYPE_BULK = 16'hE620;
  localparam logic [15:0] ADDR_SMALL_ARM = 16'hE621;
  localparam logic [15:0] ADDR_SPEED = 16'hE622;

  // ==========================================================================
  // Fields
  localparam int AUTO_OUT_COMMIT_BIT = 4;
  localparam int DIR_IN_BIT = 0;
  localparam int DISCARD_BIT = 7;
  localparam int IN_NAK_COMBINED_BIT = 0;
  localparam int LARGE_CNT_W = 11;
  localparam int SMALL_CNT_W = 10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ERR_CNT_RESET = 8'h04;

  // In-NAK bit order: ep0, ep1, ep2, ep4, ep6, ep8; large endpoint k -> bit k+2
  // Ping/NAK request bit order: bit 0 combined, bit k+2 ping for large ep k,
  // bits 1, 6 and 7 never set; small endpoints have no ping flag.

  // ==========================================================================
  // Token and handshake codes on the link
  typedef enum logic [1:0] {UEA_TOK_NONE, UEA_TOK_IN, UEA_TOK_OUT, UEA_TOK_PING} uea_tok_e;
  typedef enum logic [1:0] {UEA_HS_NONE, UEA_HS_ACK, UEA_HS_NAK, UEA_HS_DATA} uea_hs_e;

endpackage

/* File: logic/uea_link_if.sv */
// Link between the host-side token source and the device endpoint logic.
// Assumes both ends share SYS_CLK; one token per pulse, one answer per token except a full-speed PING.
`timescale 1ns/1ps
interface uea_link_if;
  logic tok_valid;
  uea_pkg::uea_tok_e tok_kind;
  logic [2:0] tok_ep;
  logic [10:0] tok_len;
  logic high_speed;
  logic hs_valid;
  uea_pkg::uea_hs_e hs_kind;
  logic [10:0] hs_len;

  modport device (input tok_valid, input tok_kind, input tok_ep, input tok_len, input high_speed,
    output hs_valid, output hs_kind, output hs_len);
  modport host (output tok_valid, output tok_kind, output tok_ep, output tok_len, output high_speed,
    input hs_valid, input hs_kind, input hs_len);
endinterface

/* File: logic/uea_device.sv */
// Device end: byte counts, arming, skip/commit, IN-NAK, PING and endpoint IRQs.
// Assumes firmware on the plain register port and a token source on the link.
// How it works
// - Endpoints 2 and 6 hold 11-bit counts
// - Endpoints 4 and 8 hold 10-bit counts
// - IN: low count write arms endpoint
// - OUT: count reads received bytes; low rearms
// - Auto commit off: interrupt, wait rearm
// - Rearm with discard clear commits packet
// - Rearm with discard set drops packet
// - Auto commit lives in config bit 4
// - Bulk IN NAKs until armed, then data
// - Each IN NAK on a bulk endpoint sets its IN-NAK flag
// - IN-NAK bits for six endpoints, bulk only
// - Combined IN-NAK sets on a NAK with no IN-NAK bit pending
// - Enable by one; write one clears
// - High-speed PING: ACK if space, else NAK
// - PING NAK on a bulk endpoint sets ping flag
// - PING only at high speed
// - Endpoint flag on buffer free or data
// - Small endpoints flag on busy fall
// - Written ones clear, zeros keep
// - Firmware clears individual before combined IN-NAK
// - Firmware clears ping flag after servicing
// - Common registers at fixed addresses
// - IN low count write sets busy
`timescale 1ns/1ps
module uea_device (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Firmware register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Output FIFO commit port
  output logic COMMIT_VALID,
  output logic [1:0] COMMIT_EP,
  output logic [10:0] COMMIT_LEN,
  // Shared interrupt
  output logic SHARED_USB_INTERRUPT,
  // Link
  uea_link_if.device LINK
);

  // ==========================================================================
  // State
  logic [10:0] count_reg [4];
  logic [3:0] busy_reg;
  logic [7:0] cfg_reg [4];
  logic [7:0] type_bulk_reg;
  logic [1:0] small_busy_reg;
  logic [7:0] in_nak_en_reg, in_nak_rq_reg, ping_en_reg, ping_rq_reg;
  logic [7:0] usb_en_reg, usb_rq_reg, ep_en_reg, ep_rq_reg;
  logic [7:0] err_en_reg, err_rq_reg, err_cnt_reg, toggle_reg;
  logic [7:0] rdata_reg;
  logic [1:0] li;
  logic [2:0] lk;
  logic wr_low, wr_high, large_hit;
  logic [7:0] nak_set, ping_set, ep_set;
  logic in_nak_any;
  logic [10:0] cnt_mask [4];

  // Count widths follow buffer size
  assign cnt_mask[0] = 11'h7FF;
  assign cnt_mask[1] = 11'h3FF;
  assign cnt_mask[2] = 11'h7FF;
  assign cnt_mask[3] = 11'h3FF;

  // ==========================================================================
  // Address decode of byte-count registers
  always_comb begin
    large_hit = 1'b0;
    li = 2'd0;
    if (REG_ADDR[15:4] == uea_pkg::ADDR_EP2_CNT_HIGH[15:4] && REG_ADDR[3:2] == 2'b00) begin
      large_hit = 1'b1;
      li = 2'd0;
    end else if (REG_ADDR[15:4] == uea_pkg::ADDR_EP2_CNT_HIGH[15:4] && REG_ADDR[3:2] == 2'b01) begin
      large_hit = 1'b1;
      li = 2'd1;
    end else if (REG_ADDR[15:4] == uea_pkg::ADDR_EP2_CNT_HIGH[15:4] && REG_ADDR[3:2] == 2'b10) begin
      large_hit = 1'b1;
      li = 2'd2;
    end else if (REG_ADDR[15:4] == uea_pkg::ADDR_EP2_CNT_HIGH[15:4] && REG_ADDR[3:2] == 2'b11) begin
      large_hit = 1'b1;
      li = 2'd3;
    end
  end
  assign wr_high = REG_WR && large_hit && REG_ADDR[1:0] == 2'b00;
  assign wr_low = REG_WR && large_hit && REG_ADDR[1:0] == 2'b01;
  // Code 7 stands for endpoint 8, which the 3-bit field cannot hold
  assign lk = (LINK.tok_ep == 3'd2) ? 3'd0 : (LINK.tok_ep == 3'd4) ? 3'd1 :
              (LINK.tok_ep == 3'd6) ? 3'd2 : (LINK.tok_ep == 3'd7) ? 3'd3 : 3'd4;

  // ==========================================================================
  // Byte counts, busy and commit
  // Large endpoints are single-buffered here; multi-packet depth is left out.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 4; i++) count_reg[i] <= '0;
      busy_reg <= '0;
      COMMIT_VALID <= 1'b0;
      COMMIT_EP <= '0;
      COMMIT_LEN <= '0;
    end else begin
      COMMIT_VALID <= 1'b0;
      if (wr_high) begin
        count_reg[li] <= {REG_WDATA[2:0], count_reg[li][7:0]} & cnt_mask[li];
      end else if (wr_low && cfg_reg[li][uea_pkg::DIR_IN_BIT]) begin
        count_reg[li] <= {count_reg[li][10:8], REG_WDATA} & cnt_mask[li];
        busy_reg[li] <= 1'b1;
      end else if (wr_low) begin
        busy_reg[li] <= 1'b0;
        if (!cfg_reg[li][uea_pkg::AUTO_OUT_COMMIT_BIT] && busy_reg[li]) begin
          COMMIT_VALID <= !REG_WDATA[uea_pkg::DISCARD_BIT];
          COMMIT_EP <= li;
          COMMIT_LEN <= count_reg[li];
        end
      end
      if (LINK.tok_valid && lk < 3'd4 && LINK.hs_kind == uea_pkg::UEA_HS_DATA) begin
        busy_reg[lk[1:0]] <= 1'b0;
      end
      if (LINK.tok_valid && lk < 3'd4 && LINK.tok_kind == uea_pkg::UEA_TOK_OUT &&
          !cfg_reg[lk[1:0]][uea_pkg::DIR_IN_BIT] && !busy_reg[lk[1:0]]) begin
        count_reg[lk[1:0]] <= LINK.tok_len & cnt_mask[lk[1:0]];
        if (cfg_reg[lk[1:0]][uea_pkg::AUTO_OUT_COMMIT_BIT]) begin
          COMMIT_VALID <= 1'b1;
          COMMIT_EP <= lk[1:0];
          COMMIT_LEN <= LINK.tok_len;
        end else begin
          busy_reg[lk[1:0]] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Link answer, combinational from current state
  always_comb begin
    LINK.hs_valid = LINK.tok_valid;
    LINK.hs_kind = uea_pkg::UEA_HS_NONE;
    LINK.hs_len = '0;
    nak_set = '0;
    ping_set = '0;
    if (LINK.tok_valid && lk < 3'd4) begin
      if (LINK.tok_kind == uea_pkg::UEA_TOK_IN) begin
        if (busy_reg[lk[1:0]]) begin
          LINK.hs_kind = uea_pkg::UEA_HS_DATA;
          LINK.hs_len = count_reg[lk[1:0]];
        end else begin
          LINK.hs_kind = uea_pkg::UEA_HS_NAK;
          nak_set[lk + 3'd2] = type_bulk_reg[lk + 3'd2];
        end
      end else if (LINK.tok_kind == uea_pkg::UEA_TOK_PING) begin
        if (!LINK.high_speed) begin
          LINK.hs_valid = 1'b0;
        end else if (!busy_reg[lk[1:0]]) begin
          LINK.hs_kind = uea_pkg::UEA_HS_ACK;
        end else begin
          LINK.hs_kind = uea_pkg::UEA_HS_NAK;
          ping_set[lk + 3'd2] = type_bulk_reg[lk + 3'd2];
        end
      end else if (LINK.tok_kind == uea_pkg::UEA_TOK_OUT) begin
        LINK.hs_kind = busy_reg[lk[1:0]] ? uea_pkg::UEA_HS_NAK : uea_pkg::UEA_HS_ACK;
      end
    end else if (LINK.tok_valid && LINK.tok_kind == uea_pkg::UEA_TOK_IN && LINK.tok_ep < 3'd2) begin
      LINK.hs_kind = small_busy_reg[LINK.tok_ep[0]] ? uea_pkg::UEA_HS_DATA : uea_pkg::UEA_HS_NAK;
      nak_set[LINK.tok_ep[0]] = !small_busy_reg[LINK.tok_ep[0]] && type_bulk_reg[LINK.tok_ep[0]];
    end
  end

  // Endpoint events: IN buffer freed, OUT packet landed, small busy falls
  always_comb begin
    ep_set = '0;
    for (int i = 0; i < 4; i++) begin
      if (LINK.tok_valid && lk == 3'(i) && busy_reg[i] == cfg_reg[i][uea_pkg::DIR_IN_BIT] &&
          (LINK.hs_kind == uea_pkg::UEA_HS_DATA ||
           (LINK.tok_kind == uea_pkg::UEA_TOK_OUT && LINK.hs_kind == uea_pkg::UEA_HS_ACK))) begin
        ep_set[i + 2] = 1'b1;
      end
    end
    for (int s = 0; s < 2; s++) begin
      if (LINK.tok_valid && LINK.tok_ep == 3'(s) && LINK.hs_kind == uea_pkg::UEA_HS_DATA) begin
        ep_set[s] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Configuration and enables
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 4; i++) cfg_reg[i] <= uea_pkg::RESET_BYTE;
      type_bulk_reg <= uea_pkg::RESET_BYTE;
      in_nak_en_reg <= uea_pkg::RESET_BYTE;
      ping_en_reg <= uea_pkg::RESET_BYTE;
      usb_en_reg <= uea_pkg::RESET_BYTE;
      ep_en_reg <= uea_pkg::RESET_BYTE;
      err_en_reg <= uea_pkg::RESET_BYTE;
      err_cnt_reg <= uea_pkg::ERR_CNT_RESET;
      toggle_reg <= uea_pkg::RESET_BYTE;
      small_busy_reg <= '0;
    end else begin
      if (REG_WR) begin
        if (REG_ADDR[15:2] == uea_pkg::ADDR_FIFO_CFG_BASE[15:2]) cfg_reg[REG_ADDR[1:0]] <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_EP_TYPE_BULK) type_bulk_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_IN_NAK_EN) in_nak_en_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_PING_NAK_EN) ping_en_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_USB_EV_EN) usb_en_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_EP_EN) ep_en_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_ERR_EN) err_en_reg <= REG_WDATA;
        else if (REG_ADDR == uea_pkg::ADDR_ERR_CNT) err_cnt_reg <= {err_cnt_reg[7:4], REG_WDATA[3:0]};
        else if (REG_ADDR == uea_pkg::ADDR_ERR_CLR) err_cnt_reg <= {4'h0, err_cnt_reg[3:0]};
        else if (REG_ADDR == uea_pkg::ADDR_TOGGLE) toggle_reg <= {1'b0, REG_WDATA[6:0]};
      end
      for (int s = 0; s < 2; s++) begin
        if (REG_WR && REG_ADDR == uea_pkg::ADDR_SMALL_ARM && REG_WDATA[s]) small_busy_reg[s] <= 1'b1;
        else if (ep_set[s]) small_busy_reg[s] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Request flags; a set in the clearing cycle wins
  assign in_nak_any = |(in_nak_rq_reg & 8'h3F);
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      in_nak_rq_reg <= uea_pkg::RESET_BYTE;
      ping_rq_reg <= uea_pkg::RESET_BYTE;
      usb_rq_reg <= uea_pkg::RESET_BYTE;
      ep_rq_reg <= uea_pkg::RESET_BYTE;
      err_rq_reg <= uea_pkg::RESET_BYTE;
    end else begin
      in_nak_rq_reg <= ((REG_WR && REG_ADDR == uea_pkg::ADDR_IN_NAK_RQ) ?
        in_nak_rq_reg & ~REG_WDATA : in_nak_rq_reg) | nak_set;
      ping_rq_reg <= ((REG_WR && REG_ADDR == uea_pkg::ADDR_PING_NAK_RQ) ?
        ping_rq_reg & ~REG_WDATA : ping_rq_reg) | ping_set |
        {7'h00, (|nak_set) && !in_nak_any};
      usb_rq_reg <= (REG_WR && REG_ADDR == uea_pkg::ADDR_USB_EV_RQ) ? usb_rq_reg & ~REG_WDATA : usb_rq_reg;
      ep_rq_reg <= ((REG_WR && REG_ADDR == uea_pkg::ADDR_EP_RQ) ?
        ep_rq_reg & ~REG_WDATA : ep_rq_reg) | ep_set;
      err_rq_reg <= (REG_WR && REG_ADDR == uea_pkg::ADDR_ERR_RQ) ? err_rq_reg & ~REG_WDATA : err_rq_reg;
    end
  end

  assign SHARED_USB_INTERRUPT = |{in_nak_rq_reg & in_nak_en_reg, ping_rq_reg & ping_en_reg,
    usb_rq_reg & usb_en_reg, ep_rq_reg & ep_en_reg, err_rq_reg & err_en_reg};

  // ==========================================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= uea_pkg::RESET_BYTE;
    end else if (REG_RD) begin
      if (large_hit && REG_ADDR[1:0] == 2'b00) rdata_reg <= {5'h00, count_reg[li][10:8]};
      else if (large_hit && REG_ADDR[1:0] == 2'b01) rdata_reg <= count_reg[li][7:0];
      else if (REG_ADDR[15:2] == uea_pkg::ADDR_FIFO_CFG_BASE[15:2]) rdata_reg <= cfg_reg[REG_ADDR[1:0]];
      else if (REG_ADDR == uea_pkg::ADDR_EP_TYPE_BULK) rdata_reg <= type_bulk_reg;
      else if (REG_ADDR == uea_pkg::ADDR_SMALL_ARM) rdata_reg <= {6'h00, small_busy_reg};
      else if (REG_ADDR == uea_pkg::ADDR_SPEED) rdata_reg <= {7'h00, LINK.high_speed};
      else if (REG_ADDR == uea_pkg::ADDR_IN_NAK_EN) rdata_reg <= in_nak_en_reg;
      else if (REG_ADDR == uea_pkg::ADDR_IN_NAK_RQ) rdata_reg <= in_nak_rq_reg;
      else if (REG_ADDR == uea_pkg::ADDR_PING_NAK_EN) rdata_reg <= ping_en_reg;
      else if (REG_ADDR == uea_pkg::ADDR_PING_NAK_RQ) rdata_reg <= ping_rq_reg;
      else if (REG_ADDR == uea_pkg::ADDR_USB_EV_EN) rdata_reg <= usb_en_reg;
      else if (REG_ADDR == uea_pkg::ADDR_USB_EV_RQ) rdata_reg <= usb_rq_reg;
      else if (REG_ADDR == uea_pkg::ADDR_EP_EN) rdata_reg <= ep_en_reg;
      else if (REG_ADDR == uea_pkg::ADDR_EP_RQ) rdata_reg <= ep_rq_reg;
      else if (REG_ADDR == uea_pkg::ADDR_ERR_EN) rdata_reg <= err_en_reg;
      else if (REG_ADDR == uea_pkg::ADDR_ERR_RQ) rdata_reg <= err_rq_reg;
      else if (REG_ADDR == uea_pkg::ADDR_ERR_CNT) rdata_reg <= err_cnt_reg;
      else if (REG_ADDR == uea_pkg::ADDR_TOGGLE) rdata_reg <= toggle_reg;
      else rdata_reg <= uea_pkg::RESET_BYTE;
    end else begin
      rdata_reg <= uea_pkg::RESET_BYTE;
    end
  end
  assign REG_RDATA = rdata_reg;

endmodule

/* File: logic/uea_host.sv */
// Host end: issues IN, OUT and PING tokens on request and reports the answer.
// Assumes the device answers in the same cycle as the token.
`timescale 1ns/1ps
module uea_host (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // User request
  input wire logic REQ_VALID,
  input wire uea_pkg::uea_tok_e REQ_KIND,
  input wire logic [2:0] REQ_EP,
  input wire logic [10:0] REQ_LEN,
  input wire logic HIGH_SPEED,
  // User answer
  output logic ANS_VALID,
  output uea_pkg::uea_hs_e ANS_KIND,
  output logic [10:0] ANS_LEN,
  // Link
  uea_link_if.host LINK
);

  // ==========================================================================
  // Token drive; PING only meaningful at high speed
  assign LINK.tok_valid = REQ_VALID;
  assign LINK.tok_kind = REQ_KIND;
  assign LINK.tok_ep = REQ_EP;
  assign LINK.tok_len = REQ_LEN;
  assign LINK.high_speed = HIGH_SPEED;

  // ==========================================================================
  // Answer capture, registered for the user
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANS_VALID <= 1'b0;
      ANS_KIND <= uea_pkg::UEA_HS_NONE;
      ANS_LEN <= '0;
    end else begin
      ANS_VALID <= REQ_VALID && LINK.hs_valid;
      ANS_KIND <= LINK.hs_valid ? LINK.hs_kind : uea_pkg::UEA_HS_NONE;
      ANS_LEN <= LINK.hs_len;
    end
  end

endmodule

/* File: tb/uea_link_checker.sv */
// Link checker: token to handshake relations on the shared link.
// Assumes one clock; sees only the interface's signals, instantiated by the top.
`timescale 1ns/1ps
module uea_link_checker (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Token side
  input wire logic tok_valid,
  input wire uea_pkg::uea_tok_e tok_kind,
  input wire logic [2:0] tok_ep,
  input wire logic [10:0] tok_len,
  input wire logic high_speed,
  // Answer side
  input wire logic hs_valid,
  input wire uea_pkg::uea_hs_e hs_kind,
  input wire logic [10:0] hs_len
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  logic large_ep;
  // Endpoint 8 travels as code 7 in the 3-bit field
  assign large_ep = (tok_ep == 3'h2) || (tok_ep == 3'h4) || (tok_ep == 3'h6) || (tok_ep == 3'h7);

  // ==========================================================================
  // Assertions
  a_answer_same_cycle: assert property (tok_valid && large_ep && (tok_kind inside {uea_pkg::UEA_TOK_IN,
    uea_pkg::UEA_TOK_OUT}) |-> hs_valid) else $error("no answer to token");
  a_no_stray_answer: assert property (!tok_valid |-> !hs_valid) else $error("answer without token");
  a_ping_fs_silent: assert property (
    tok_valid && tok_kind == uea_pkg::UEA_TOK_PING && !high_speed |-> !hs_valid)
    else $error("ping answered at full speed");
  a_ping_ack_nak: assert property (
    tok_valid && tok_kind == uea_pkg::UEA_TOK_PING && high_speed && hs_valid
    |-> hs_kind inside {uea_pkg::UEA_HS_ACK, uea_pkg::UEA_HS_NAK}) else $error("bad ping answer");
  a_in_nak_data: assert property (
    tok_valid && tok_kind == uea_pkg::UEA_TOK_IN && hs_valid
    |-> hs_kind inside {uea_pkg::UEA_HS_NAK, uea_pkg::UEA_HS_DATA}) else $error("bad in answer");
  a_out_ack_nak: assert property (
    tok_valid && tok_kind == uea_pkg::UEA_TOK_OUT && hs_valid
    |-> hs_kind inside {uea_pkg::UEA_HS_ACK, uea_pkg::UEA_HS_NAK}) else $error("bad out answer");
  a_data_only_in: assert property (
    hs_valid && hs_kind == uea_pkg::UEA_HS_DATA |-> tok_valid && tok_kind == uea_pkg::UEA_TOK_IN)
    else $error("data without in token");
  a_short_count_max: assert property (
    tok_valid && (tok_ep == 3'h4 || tok_ep == 3'h7) && hs_valid && hs_kind == uea_pkg::UEA_HS_DATA
    |-> hs_len[10] == 1'b0)
    else $error("ten bit count exceeded");
endmodule

/* File: tb/usb_endpoint_arm_and_nak_interrupts_tb_top.sv */
// Top bench: both ends joined by the link, firmware port and user side driven here.
// Assumes the device answers in the token's cycle and reads return one cycle later.
`timescale 1ns/1ps
module usb_endpoint_arm_and_nak_interrupts_tb_top;
  // ==========================================================================
  // Signals
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic commit_valid;
  logic [1:0] commit_ep;
  logic [10:0] commit_len;
  logic shared_irq;
  logic req_valid = 1'b0;
  uea_pkg::uea_tok_e req_kind = uea_pkg::UEA_TOK_NONE;
  logic [2:0] req_ep = 3'h0;
  logic [10:0] req_len = 11'h000;
  logic high_speed = 1'b1;
  logic ans_valid;
  uea_pkg::uea_hs_e ans_kind;
  logic [10:0] ans_len;
  logic [7:0] commits = 8'h00;
  logic [10:0] last_len = 11'h000;
  logic [1:0] last_ep = 2'h0;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 sys_clk = ~sys_clk;

  // ==========================================================================
  // Instances
  uea_link_if i_uea_link_if ();
  uea_device i_uea_device (.SYS_CLK(sys_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .COMMIT_VALID(commit_valid), .COMMIT_EP(commit_ep),
    .COMMIT_LEN(commit_len), .SHARED_USB_INTERRUPT(shared_irq), .LINK(i_uea_link_if.device));
  uea_host i_uea_host (.SYS_CLK(sys_clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
    .REQ_EP(req_ep), .REQ_LEN(req_len), .HIGH_SPEED(high_speed), .ANS_VALID(ans_valid), .ANS_KIND(ans_kind),
    .ANS_LEN(ans_len), .LINK(i_uea_link_if.host));
  uea_link_checker i_uea_link_checker (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .tok_valid(i_uea_link_if.tok_valid), .tok_kind(i_uea_link_if.tok_kind), .tok_ep(i_uea_link_if.tok_ep),
    .tok_len(i_uea_link_if.tok_len), .high_speed(i_uea_link_if.high_speed), .hs_valid(i_uea_link_if.hs_valid),
    .hs_kind(i_uea_link_if.hs_kind), .hs_len(i_uea_link_if.hs_len));

  // ==========================================================================
  // Commit monitor and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (commit_valid === 1'b1) begin
      commits <= commits + 8'h01;
      last_len <= commit_len;
      last_ep <= commit_ep;
    end
    // Whole run is well under a thousand cycles
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      results();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // No answer expected when exp_kind is none; length only matters for data
  task automatic tok(input uea_pkg::uea_tok_e kind, input logic [2:0] ep, input logic [10:0] len,
    input uea_pkg::uea_hs_e exp_kind, input logic [10:0] exp_len);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_kind <= kind;
    req_ep <= ep;
    req_len <= len;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    check({15'h0000, ans_valid}, {15'h0000, exp_kind != uea_pkg::UEA_HS_NONE});
    if (exp_kind != uea_pkg::UEA_HS_NONE) begin
      check({14'h0000, ans_kind}, {14'h0000, exp_kind});
      if (exp_kind == uea_pkg::UEA_HS_DATA) begin
        check({5'h00, ans_len}, {5'h00, exp_len});
      end
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values, error limit default and an unmapped place
    rd(uea_pkg::ADDR_IN_NAK_RQ, 8'h00);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h00);
    rd(uea_pkg::ADDR_EP_RQ, 8'h00);
    rd(uea_pkg::ADDR_ERR_CNT, uea_pkg::ERR_CNT_RESET);
    rd(16'hE600, 8'h00);
    $display("Test reset done");
    // Bulk IN on endpoint 2: NAK flags, combined bit, enables
    wr(uea_pkg::ADDR_EP_TYPE_BULK, 8'h3F);
    wr(uea_pkg::ADDR_FIFO_CFG_BASE, 8'h01);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    rd(uea_pkg::ADDR_IN_NAK_RQ, 8'h04);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h01);
    check({15'h0000, shared_irq}, 16'h0000);
    wr(uea_pkg::ADDR_IN_NAK_EN, 8'h04);
    wr(uea_pkg::ADDR_PING_NAK_EN, 8'h01);
    @(negedge sys_clk);
    check({15'h0000, shared_irq}, 16'h0001);
    wr(uea_pkg::ADDR_PING_NAK_RQ, 8'h01);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h00);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h00);
    wr(uea_pkg::ADDR_IN_NAK_RQ, 8'hFF);
    rd(uea_pkg::ADDR_IN_NAK_RQ, 8'h00);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h01);
    wr(uea_pkg::ADDR_IN_NAK_RQ, 8'h04);
    wr(uea_pkg::ADDR_PING_NAK_RQ, 8'h01);
    @(negedge sys_clk);
    check({15'h0000, shared_irq}, 16'h0000);
    // Arming: high byte alone does not arm, low byte does
    wr(uea_pkg::ADDR_EP2_CNT_HIGH, 8'h01);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    wr(uea_pkg::ADDR_EP2_CNT_HIGH + 16'h0001, 8'h20);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_DATA, 11'h120);
    rd(uea_pkg::ADDR_EP_RQ, 8'h04);
    wr(uea_pkg::ADDR_EP_RQ, 8'h04);
    rd(uea_pkg::ADDR_EP_RQ, 8'h00);
    tok(uea_pkg::UEA_TOK_IN, 3'h2, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    // Endpoint 4 keeps only ten bits of count
    wr(uea_pkg::ADDR_FIFO_CFG_BASE + 16'h0001, 8'h01);
    wr(uea_pkg::ADDR_EP4_CNT_HIGH, 8'h07);
    wr(uea_pkg::ADDR_EP4_CNT_HIGH + 16'h0001, 8'hFF);
    tok(uea_pkg::UEA_TOK_IN, 3'h4, 11'h000, uea_pkg::UEA_HS_DATA, 11'h3FF);
    $display("Test in_nak done");
    // OUT on endpoint 6 with the firmware hook
    wr(uea_pkg::ADDR_IN_NAK_RQ, 8'hFF);
    wr(uea_pkg::ADDR_PING_NAK_RQ, 8'hFF);
    wr(uea_pkg::ADDR_EP_RQ, 8'hFF);
    // Small endpoint 0: flag rises as busy falls
    wr(uea_pkg::ADDR_SMALL_ARM, 8'h01);
    tok(uea_pkg::UEA_TOK_IN, 3'h0, 11'h000, uea_pkg::UEA_HS_DATA, 11'h000);
    rd(uea_pkg::ADDR_EP_RQ, 8'h01);
    rd(uea_pkg::ADDR_SMALL_ARM, 8'h00);
    wr(uea_pkg::ADDR_EP_RQ, 8'h01);
    wr(uea_pkg::ADDR_FIFO_CFG_BASE + 16'h0002, 8'h00);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h010, uea_pkg::UEA_HS_ACK, 11'h000);
    rd(uea_pkg::ADDR_EP6_CNT_HIGH + 16'h0001, 8'h10);
    rd(uea_pkg::ADDR_EP6_CNT_HIGH, 8'h00);
    rd(uea_pkg::ADDR_EP_RQ, 8'h10);
    check({8'h00, commits}, 16'h0000);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h010, uea_pkg::UEA_HS_NAK, 11'h000);
    tok(uea_pkg::UEA_TOK_PING, 3'h6, 11'h000, uea_pkg::UEA_HS_NAK, 11'h000);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h10);
    @(posedge sys_clk) high_speed <= 1'b0;
    tok(uea_pkg::UEA_TOK_PING, 3'h6, 11'h000, uea_pkg::UEA_HS_NONE, 11'h000);
    @(posedge sys_clk) high_speed <= 1'b1;
    wr(uea_pkg::ADDR_EP6_CNT_HIGH + 16'h0001, 8'h00);
    repeat (3) @(negedge sys_clk);
    check({8'h00, commits}, 16'h0001);
    check({5'h00, last_len}, 16'h0010);
    check({14'h0000, last_ep}, 16'h0002);
    wr(uea_pkg::ADDR_PING_NAK_RQ, 8'h10);
    rd(uea_pkg::ADDR_PING_NAK_RQ, 8'h00);
    tok(uea_pkg::UEA_TOK_PING, 3'h6, 11'h000, uea_pkg::UEA_HS_ACK, 11'h000);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h008, uea_pkg::UEA_HS_ACK, 11'h000);
    wr(uea_pkg::ADDR_EP6_CNT_HIGH + 16'h0001, 8'h80);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h003, uea_pkg::UEA_HS_ACK, 11'h000);
    wr(uea_pkg::ADDR_EP6_CNT_HIGH + 16'h0001, 8'h80);
    repeat (3) @(negedge sys_clk);
    check({8'h00, commits}, 16'h0001);
    // Automatic commit passes packets straight on
    wr(uea_pkg::ADDR_FIFO_CFG_BASE + 16'h0002, 8'h10);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h005, uea_pkg::UEA_HS_ACK, 11'h000);
    tok(uea_pkg::UEA_TOK_OUT, 3'h6, 11'h006, uea_pkg::UEA_HS_ACK, 11'h000);
    repeat (3) @(negedge sys_clk);
    check({8'h00, commits}, 16'h0003);
    check({5'h00, last_len}, 16'h0006);
    $display("Test out_commit done");
    results();
  end
endmodule
